// ==== rtl/pmr_consts.vh ====
`ifndef PMR_CONSTS_VH
`define PMR_CONSTS_VH
// ****************************************
// mode encodings
// ****************************************
`define PMR_MODE_KERNEL 2'h0
`define PMR_MODE_USER 2'h1
`define PMR_MODE_DEBUG 2'h2
// ****************************************
// register numbers and map selects
// ****************************************
`define PMR_REG_ZERO 5'h00
`define PMR_REG_S0 5'h10
`define PMR_REG_S1 5'h11
`define PMR_REG_COND 5'h18
`define PMR_REG_GP 5'h1c
`define PMR_REG_SP 5'h1d
`define PMR_REG_RA 5'h1f
`define PMR_MAP_FIRST 1'h0
`define PMR_MAP_SECOND 1'h1
// ****************************************
// address space limits
// ****************************************
`define PMR_USER_LIMIT 32'h80000000
`define PMR_PERIPH_BASE 32'ha0000000
`define PMR_PERIPH_TOP 32'hc0000000
// ****************************************
// reset values
// ****************************************
`define PMR_RST_EXL 1'h0
`define PMR_RST_ERL 1'h1
`define PMR_RST_UM 1'h0
`define PMR_RST_DM 1'h0
`endif

// ==== rtl/pmr_regmap.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.vh"
// ****************************************
// compact register field to register number
// ****************************************
module pmr_regmap (
  // selects
  input wire map_sel,
  input wire zero_for_code0,
  // field
  input wire [2:0] code,
  // result
  output reg [4:0] reg_num
);
  // codes 0 and 1 fold onto the saved registers; code 0 under the second map with zero_for_code0 gives register 0
  always @* begin
    case (code)
      3'h0: begin
        if (map_sel == `PMR_MAP_SECOND && zero_for_code0) begin
          reg_num = `PMR_REG_ZERO;
        end else begin
          reg_num = `PMR_REG_S0;
        end
      end
      3'h1: reg_num = `PMR_REG_S1;
      default: reg_num = {2'h0, code};
    endcase
  end
endmodule
`default_nettype wire

// ==== rtl/pmr_muldiv.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.vh"
// ****************************************
// high and low result registers
// ****************************************
module pmr_muldiv #(
  parameter W = 32
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // operation
  input wire op_mul,
  input wire op_div,
  input wire [W-1:0] op_a,
  input wire [W-1:0] op_b,
  // results
  output reg [W-1:0] product_high_word,
  output reg [W-1:0] product_low_word
);
  wire [2*W-1:0] prod = op_a * op_b;
  // a zero divisor leaves results unchanged rather than guess a value
  wire div_ok = (op_b != {W{1'b0}});
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      product_high_word <= {W{1'b0}};
      product_low_word <= {W{1'b0}};
    end else if (op_mul) begin
      product_high_word <= prod[2*W-1:W];
      product_low_word <= prod[W-1:0];
    end else if (op_div && div_ok) begin
      product_high_word <= op_a % op_b;
      product_low_word <= op_a / op_b;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/pmr_core.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.vh"
// Notes on behaviour
// - first map: 0,1 to 16,17; cmp uses 24
// - second map: 0 to 16 or 0, 1 to 17
// - second map implies gp 28, sp 29, ra 31
// - pc-relative ops take current pc as operand
// - result high word and low word registers
// - divide: quotient low, remainder high
// - no hardware stack; software keeps it
// - start in kernel mode after reset
// - user mode cannot reach peripheral space
// - kernel when not debug and um0/erl/exl
// - kernel reaches all space and privileged ops
// - non-debug exception sets exl or erl
// - exception return picks pc, clears erl/exl
// - um1 resumes user once both levels clear
// - user only when um1, exl0, erl0
// - user limited to user segment, system_call_instr entry
// - debug only via debug exception, extra resources
// - debug reported on MODE one cycle after debug flag set
// - debug return leaves debug for status mode
module pmr_core #(
  parameter W = 32
) (
  // clock and reset
  input wire CLK,
  input wire RST_N,
  // status configuration
  input wire UM_WR,
  input wire UM_WDATA,
  // exceptions and returns
  input wire EXC_REQ,
  input wire EXC_IS_ERROR,
  input wire DBG_EXC_REQ,
  input wire EXCEPTION_RETURN_INSTR_REQ,
  input wire DEBUG_RETURN_INSTR_REQ,
  input wire [W-1:0] EXC_PC,
  input wire [W-1:0] DBG_PC,
  // access checks
  input wire ACC_VALID,
  input wire [W-1:0] ACC_ADDR,
  input wire PRIV_INSTR,
  // compact register decode
  input wire MAP_SEL,
  input wire ZERO_FOR_CODE0,
  input wire [2:0] REG_CODE,
  input wire IMPL_COND,
  input wire [1:0] IMPL_SEL,
  // pc-relative operand
  input wire PCREL,
  input wire [W-1:0] CUR_PC,
  input wire [W-1:0] PCREL_OFFSET,
  // multiply and divide
  input wire OP_MUL,
  input wire OP_DIV,
  input wire [W-1:0] OP_A,
  input wire [W-1:0] OP_B,
  // mode and flags
  output reg [1:0] MODE,
  output reg USER_MODE_SELECT,
  output reg EXCEPTION_LEVEL_FLAG,
  output reg ERROR_LEVEL_FLAG,
  output reg DEBUG_MODE_FLAG,
  output reg DEBUG_RES_EN,
  // returns
  output reg RET_VALID,
  output reg [W-1:0] RET_PC,
  output reg [W-1:0] EXCEPTION_RETURN_PC,
  output reg [W-1:0] ERROR_RETURN_PC,
  output reg [W-1:0] DEBUG_RETURN_PC,
  // faults
  output reg ADDR_ERR,
  output reg PRIV_ERR,
  output reg ACC_GRANT,
  // decode results
  output reg [4:0] REG_NUM,
  output reg [W-1:0] PCREL_VALUE,
  output reg [W-1:0] PRODUCT_HIGH_WORD,
  output reg [W-1:0] PRODUCT_LOW_WORD
);
  // ****************************************
  // mode selection
  // ****************************************
  reg [1:0] mode_now;
  wire kernel_now = (mode_now == `PMR_MODE_KERNEL);
  wire user_now = (mode_now == `PMR_MODE_USER);
  // debug flag overrides the status flags
  always @* begin
    if (DEBUG_MODE_FLAG) begin
      mode_now = `PMR_MODE_DEBUG;
    end else if (!USER_MODE_SELECT || ERROR_LEVEL_FLAG || EXCEPTION_LEVEL_FLAG) begin
      mode_now = `PMR_MODE_KERNEL;
    end else begin
      mode_now = `PMR_MODE_USER;
    end
  end
  // ****************************************
  // access checks
  // ****************************************
  // declared ahead of the flag process, which raises an exception on a fault
  wire in_user_seg = (ACC_ADDR < `PMR_USER_LIMIT);
  wire in_periph = (ACC_ADDR >= `PMR_PERIPH_BASE) && (ACC_ADDR < `PMR_PERIPH_TOP);
  // user software sees only the low segment; peripherals lie above it
  wire next_addr_err = ACC_VALID && user_now && !in_user_seg;
  wire next_priv_err = PRIV_INSTR && user_now;
  wire next_fault = next_addr_err || next_priv_err;
  // kernel and debug reach the whole space
  wire next_grant = ACC_VALID && (!user_now || (in_user_seg && !in_periph));
  // ****************************************
  // status flags
  // ****************************************
  // the error level flag is set at reset so execution opens in kernel mode
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      USER_MODE_SELECT <= `PMR_RST_UM;
      EXCEPTION_LEVEL_FLAG <= `PMR_RST_EXL;
      ERROR_LEVEL_FLAG <= `PMR_RST_ERL;
      DEBUG_MODE_FLAG <= `PMR_RST_DM;
      EXCEPTION_RETURN_PC <= {W{1'b0}};
      ERROR_RETURN_PC <= {W{1'b0}};
      DEBUG_RETURN_PC <= {W{1'b0}};
      RET_VALID <= 1'b0;
      RET_PC <= {W{1'b0}};
    end else begin
      RET_VALID <= 1'b0;
      // only kernel or debug software may change the user mode select
      if (UM_WR && !user_now) begin
        USER_MODE_SELECT <= UM_WDATA;
      end
      if (DBG_EXC_REQ && !DEBUG_MODE_FLAG) begin
        DEBUG_MODE_FLAG <= 1'b1;
        DEBUG_RETURN_PC <= DBG_PC;
      end else if (DEBUG_RETURN_INSTR_REQ && DEBUG_MODE_FLAG) begin
        DEBUG_MODE_FLAG <= 1'b0;
        RET_VALID <= 1'b1;
        RET_PC <= DEBUG_RETURN_PC;
      end else if (EXC_REQ || next_fault) begin
        // an exception wins over an exception return in the same cycle; a debug return wins over it
        if (EXC_IS_ERROR) begin
          ERROR_LEVEL_FLAG <= 1'b1;
          ERROR_RETURN_PC <= EXC_PC;
        end else begin
          EXCEPTION_LEVEL_FLAG <= 1'b1;
          EXCEPTION_RETURN_PC <= EXC_PC;
        end
      end else if (EXCEPTION_RETURN_INSTR_REQ && !user_now) begin
        RET_VALID <= 1'b1;
        ERROR_LEVEL_FLAG <= 1'b0;
        if (ERROR_LEVEL_FLAG) begin
          RET_PC <= ERROR_RETURN_PC;
        end else begin
          RET_PC <= EXCEPTION_RETURN_PC;
          EXCEPTION_LEVEL_FLAG <= 1'b0;
        end
      end
    end
  end
  // registered access answers
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      MODE <= `PMR_MODE_KERNEL;
      DEBUG_RES_EN <= 1'b0;
      ADDR_ERR <= 1'b0;
      PRIV_ERR <= 1'b0;
      ACC_GRANT <= 1'b0;
    end else begin
      MODE <= mode_now;
      DEBUG_RES_EN <= DEBUG_MODE_FLAG;
      ADDR_ERR <= next_addr_err;
      PRIV_ERR <= next_priv_err;
      ACC_GRANT <= next_grant;
    end
  end
  // ****************************************
  // register decode and pc-relative operand
  // ****************************************
  wire [4:0] field_num;
  reg [4:0] next_reg_num;
  // the carry out is dropped on purpose: addresses wrap
  wire [W:0] pcrel_sum = CUR_PC + PCREL_OFFSET;
  pmr_regmap u_map (
    .map_sel(MAP_SEL),
    .zero_for_code0(ZERO_FOR_CODE0),
    .code(REG_CODE),
    .reg_num(field_num)
  );
  // implicit registers are never carried in a field
  always @* begin
    next_reg_num = field_num;
    if (MAP_SEL == `PMR_MAP_FIRST && IMPL_COND) begin
      next_reg_num = `PMR_REG_COND;
    end else if (MAP_SEL == `PMR_MAP_SECOND) begin
      case (IMPL_SEL)
        2'h1: next_reg_num = `PMR_REG_GP;
        2'h2: next_reg_num = `PMR_REG_SP;
        2'h3: next_reg_num = `PMR_REG_RA;
        default: next_reg_num = field_num;
      endcase
    end
  end
  // the stack pointer is an ordinary register; no push or pop logic exists
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_NUM <= 5'h00;
      PCREL_VALUE <= {W{1'b0}};
    end else begin
      REG_NUM <= next_reg_num;
      if (PCREL) begin
        PCREL_VALUE <= pcrel_sum[W-1:0];
      end
    end
  end
  // ****************************************
  // multiply and divide results
  // ****************************************
  wire [W-1:0] hi_w;
  wire [W-1:0] lo_w;
  pmr_muldiv #(.W(W)) u_md (
    .clk(CLK),
    .rst_n(RST_N),
    .op_mul(OP_MUL),
    .op_div(OP_DIV),
    .op_a(OP_A),
    .op_b(OP_B),
    .product_high_word(hi_w),
    .product_low_word(lo_w)
  );
  // extra stage keeps every top output on a flip-flop of its own
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRODUCT_HIGH_WORD <= {W{1'b0}};
      PRODUCT_LOW_WORD <= {W{1'b0}};
    end else begin
      PRODUCT_HIGH_WORD <= hi_w;
      PRODUCT_LOW_WORD <= lo_w;
    end
  end
endmodule
`default_nettype wire

// ==== dv/pmr_core_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.vh"
// ****
// mode and trap checks
// ****
module pmr_core_properties #(
  parameter W = 32
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // requests
  input wire logic EXC_REQ, EXC_IS_ERROR, DBG_EXC_REQ, EXCEPTION_RETURN_INSTR_REQ, DEBUG_RETURN_INSTR_REQ,
  input wire logic ACC_VALID, PRIV_INSTR,
  input wire logic [W-1:0] ACC_ADDR,
  // state and answers
  input wire logic [1:0] MODE,
  input wire logic USER_MODE_SELECT, EXCEPTION_LEVEL_FLAG, ERROR_LEVEL_FLAG,
  input wire logic DEBUG_MODE_FLAG, RET_VALID, ADDR_ERR, PRIV_ERR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // user by the flags; MODE trails them a cycle, so traps wait for both
  wire usr = USER_MODE_SELECT & !EXCEPTION_LEVEL_FLAG & !ERROR_LEVEL_FLAG & !DEBUG_MODE_FLAG;
  wire usr_now = usr & (MODE == `PMR_MODE_USER);
  wire quiet = !DBG_EXC_REQ & !DEBUG_RETURN_INSTR_REQ & !EXC_REQ;
  kernel_sel_a: assert property (!$past(DEBUG_MODE_FLAG) && !$past(usr) |-> MODE == `PMR_MODE_KERNEL)
    else $error("mode not kernel");
  user_sel_a: assert property ($past(usr) |-> MODE == `PMR_MODE_USER)
    else $error("mode not user");
  debug_sel_a: assert property ($past(DEBUG_MODE_FLAG) |-> MODE == `PMR_MODE_DEBUG)
    else $error("mode not debug");
  debug_entry_a: assert property ($rose(DEBUG_MODE_FLAG) |-> $past(DBG_EXC_REQ))
    else $error("debug entered without debug exception");
  exc_level_a: assert property (EXC_REQ && !DBG_EXC_REQ && !DEBUG_RETURN_INSTR_REQ && !DEBUG_MODE_FLAG |=>
    ($past(EXC_IS_ERROR) ? ERROR_LEVEL_FLAG : EXCEPTION_LEVEL_FLAG))
    else $error("exception left level flags clear");
  exception_return_instr_clear_a: assert property (EXCEPTION_RETURN_INSTR_REQ && quiet && !usr && !DEBUG_MODE_FLAG |=> RET_VALID &&
    !ERROR_LEVEL_FLAG && EXCEPTION_LEVEL_FLAG == ($past(ERROR_LEVEL_FLAG) && $past(EXCEPTION_LEVEL_FLAG)))
    else $error("exception return flags wrong");
  debug_exit_a: assert property (DEBUG_RETURN_INSTR_REQ && DEBUG_MODE_FLAG && !DBG_EXC_REQ |=> !DEBUG_MODE_FLAG)
    else $error("debug return kept debug");
  user_addr_a: assert property (ACC_VALID && usr_now && quiet && ACC_ADDR[W-1] |=> ADDR_ERR)
    else $error("user high access not trapped");
  priv_trap_a: assert property (PRIV_INSTR && usr_now && quiet |=> PRIV_ERR)
    else $error("user privileged op not trapped");
endmodule
bind pmr_core pmr_core_properties #(.W(W)) u_pmr_core_properties (.*);
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.vh"
module tb_top;
  logic CLK, RST_N, UM_WR, UM_WDATA, EXC_REQ, EXC_IS_ERROR, DBG_EXC_REQ, EXCEPTION_RETURN_INSTR_REQ, DEBUG_RETURN_INSTR_REQ;
  logic ACC_VALID, PRIV_INSTR, MAP_SEL, ZERO_FOR_CODE0, IMPL_COND, PCREL, OP_MUL, OP_DIV;
  logic [31:0] EXC_PC, DBG_PC, ACC_ADDR, CUR_PC, PCREL_OFFSET, OP_A, OP_B, RET_PC, PCREL_VALUE;
  logic [31:0] EXCEPTION_RETURN_PC, ERROR_RETURN_PC, DEBUG_RETURN_PC;
  logic [31:0] PRODUCT_HIGH_WORD, PRODUCT_LOW_WORD;
  logic [2:0] REG_CODE;
  logic [1:0] IMPL_SEL, MODE;
  logic [4:0] REG_NUM;
  logic USER_MODE_SELECT, EXCEPTION_LEVEL_FLAG, ERROR_LEVEL_FLAG, DEBUG_MODE_FLAG, DEBUG_RES_EN;
  logic RET_VALID, ADDR_ERR, PRIV_ERR, ACC_GRANT;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  pmr_core #(.W(32)) u_pmr_core (.*);
  // ****
  // clock, watchdog and helpers
  // ****
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  // a hang costs a mismatch rather than a stuck run
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(negedge CLK);
  endtask
  task automatic acc(input logic [31:0] a, input logic [31:0] pc);
    ACC_VALID = 1'b1;
    ACC_ADDR = a;
    EXC_PC = pc;
    tick();
    ACC_VALID = 1'b0;
  endtask
  // extra tick lets MODE catch up with the flags
  task automatic exception_return_instr(input logic [31:0] pc);
    EXCEPTION_RETURN_INSTR_REQ = 1'b1;
    tick();
    EXCEPTION_RETURN_INSTR_REQ = 1'b0;
    chk({RET_VALID, RET_PC}, {1'b1, pc});
    tick();
  endtask
  task wrap_up();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_modes();
    chk({MODE, ERROR_LEVEL_FLAG, EXCEPTION_LEVEL_FLAG, USER_MODE_SELECT}, 5'b00100);
    UM_WR = 1'b1;
    UM_WDATA = 1'b1;
    tick();
    UM_WR = 1'b0;
    tick();
    chk({USER_MODE_SELECT, MODE}, {1'b1, `PMR_MODE_KERNEL});
    exception_return_instr(32'h0);
    chk({ERROR_LEVEL_FLAG, EXCEPTION_LEVEL_FLAG, MODE}, {2'b00, `PMR_MODE_USER});
    acc(32'h8000_0000, 32'h1234);
    chk({ADDR_ERR, ACC_GRANT, EXCEPTION_LEVEL_FLAG, EXCEPTION_RETURN_PC}, {3'b101, 32'h1234});
    tick();
    chk(MODE, `PMR_MODE_KERNEL);
    acc(32'ha000_0000, 32'h0);
    chk({ADDR_ERR, ACC_GRANT}, 2'b01);
    exception_return_instr(32'h1234);
    acc(32'h7fff_fffc, 32'h0);
    chk({ADDR_ERR, ACC_GRANT, MODE}, {2'b01, `PMR_MODE_USER});
    acc(32'ha000_0000, 32'h2000);
    chk(ACC_GRANT, 1'b0);
    {EXC_REQ, EXC_IS_ERROR, EXC_PC} = {2'b11, 32'h5678};
    tick();
    {EXC_REQ, EXC_IS_ERROR} = 2'b00;
    chk({ERROR_LEVEL_FLAG, EXCEPTION_LEVEL_FLAG, ERROR_RETURN_PC}, {2'b11, 32'h5678});
    exception_return_instr(32'h5678);
    chk({ERROR_LEVEL_FLAG, EXCEPTION_LEVEL_FLAG}, 2'b01);
    exception_return_instr(32'h2000);
    chk(MODE, `PMR_MODE_USER);
    PRIV_INSTR = 1'b1;
    tick();
    PRIV_INSTR = 1'b0;
    chk({PRIV_ERR, EXCEPTION_LEVEL_FLAG}, 2'b11);
    $display("modes done");
  endtask
  task automatic t_debug();
    {DBG_EXC_REQ, DBG_PC} = {1'b1, 32'habc};
    tick();
    DBG_EXC_REQ = 1'b0;
    chk({DEBUG_MODE_FLAG, DEBUG_RETURN_PC}, {1'b1, 32'habc});
    tick();
    chk({MODE, DEBUG_RES_EN}, {`PMR_MODE_DEBUG, 1'b1});
    DEBUG_RETURN_INSTR_REQ = 1'b1;
    tick();
    DEBUG_RETURN_INSTR_REQ = 1'b0;
    chk({RET_VALID, DEBUG_MODE_FLAG}, 2'b10);
    tick();
    chk(MODE, `PMR_MODE_KERNEL);
    $display("debug done");
  endtask
  // every code under both maps, with and without the zero select
  task automatic t_regmap();
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 8; c++) begin
        {MAP_SEL, ZERO_FOR_CODE0, REG_CODE} = {m[1:0], c[2:0]};
        tick();
        chk(REG_NUM, (c > 1) ? c : (m == 3 && c == 0) ? 0 : 16 + c);
      end
    end
    {MAP_SEL, IMPL_COND} = 2'b01;
    tick();
    chk(REG_NUM, 24);
    {MAP_SEL, IMPL_COND} = 2'b10;
    for (int i = 1; i < 4; i++) begin
      IMPL_SEL = i[1:0];
      tick();
      chk(REG_NUM, (i == 3) ? 31 : 27 + i);
    end
    IMPL_SEL = 2'h0;
    $display("regmap done");
  endtask
  task automatic t_math();
    {PCREL, CUR_PC, PCREL_OFFSET} = {1'b1, 32'h1000, 32'hffff_fff0};
    {OP_MUL, OP_A, OP_B} = {1'b1, 32'hffff_ffff, 32'h2};
    tick();
    {PCREL, OP_MUL, OP_DIV, OP_A, OP_B} = {3'b001, 32'd100, 32'd7};
    chk(PCREL_VALUE, 32'h0ff0);
    tick();
    OP_DIV = 1'b0;
    chk({PRODUCT_HIGH_WORD, PRODUCT_LOW_WORD}, 64'h1_ffff_fffe);
    tick();
    chk({PRODUCT_HIGH_WORD, PRODUCT_LOW_WORD}, {32'd2, 32'd14});
    $display("math done");
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    RST_N = 1'b0;
    {UM_WR, UM_WDATA, EXC_REQ, EXC_IS_ERROR, DBG_EXC_REQ, EXCEPTION_RETURN_INSTR_REQ, DEBUG_RETURN_INSTR_REQ, ACC_VALID,
      PRIV_INSTR, MAP_SEL, ZERO_FOR_CODE0, IMPL_COND, PCREL, OP_MUL, OP_DIV, EXC_PC, DBG_PC,
      ACC_ADDR, CUR_PC, PCREL_OFFSET, OP_A, OP_B, REG_CODE, IMPL_SEL} = '0;
    tick(2);
    RST_N = 1'b1;
    t_modes();
    t_debug();
    t_regmap();
    t_math();
    wrap_up();
  end
endmodule
`default_nettype wire
